// [logic/udma_burst_params.svh]
// Register map, field positions, reset values and timing of the burst port
`ifndef UDMA_BURST_PARAMS_SVH
`define UDMA_BURST_PARAMS_SVH

`define UDMA_REG_CTRL 8'h00
`define UDMA_REG_MODE 8'h04
`define UDMA_REG_STATUS 8'h08
`define UDMA_REG_DATA 8'h0c
`define UDMA_REG_COUNT 8'h10
`define UDMA_REG_CRC 8'h14

`define UDMA_CTRL_START 0
`define UDMA_CTRL_DIR 1
`define UDMA_CTRL_SRST 2

`define UDMA_MODE_LSB 0
`define UDMA_MODE_MSB 2
`define UDMA_MODE_EN 3
`define UDMA_MODE_KEEP 4
`define UDMA_MODE_MEMCARD 5
`define UDMA_MODE_IDE 6
`define UDMA_MODE_ABORT 7

`define UDMA_ST_BSY 0
`define UDMA_ST_DRQ 1
`define UDMA_ST_CRCERR 2
`define UDMA_ST_BURST 3
`define UDMA_ST_ACTIVE 4
`define UDMA_ST_RXFULL 5
`define UDMA_ST_TXEMPTY 6
`define UDMA_ST_ABORTED 7
`define UDMA_ST_REJECT 8
`define UDMA_ST_CEVIOL 9

`define UDMA_MODE_RST 3'h0
`define UDMA_MAX_MODE 4
`define UDMA_CRC_SEED 16'hffff
`define UDMA_CRC_POLY 16'h1021

`define UDMA_CLK_MHZ 25
`define UDMA_T_DVS_NS 70
`define UDMA_DVS_CYC ((`UDMA_T_DVS_NS * `UDMA_CLK_MHZ + 999) / 1000)

`endif

// [logic/udma_burst_pkg.sv]
// Types shared by the burst port modules
package udma_burst_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_REQ = 2'b01,
		ST_BURST = 2'b11,
		ST_TERM = 2'b10
	} burst_state_e;

	typedef struct packed {
		logic [10:0] addr;
		logic [1:0] ce_n;
		logic dmack_n;
		logic stop;
		logic host_line;
		logic [15:0] data;
	} link_in_s;

	typedef struct packed {
		burst_state_e st;
		logic dmarq;
		logic dev_line;
		logic [15:0] data_out;
		logic data_oe;
		logic ready;
		logic [31:0] rdata;
		logic [10:0] tf_addr;
		logic [2:0] mode;
		logic udma_en;
		logic keep;
		logic memcard;
		logic ide;
		logic abort_en;
		logic cmd_active;
		logic dir;
		logic [15:0] count;
		logic crc_err;
		logic aborted;
		logic reject;
		logic ceviol;
		logic [15:0] tx_word;
		logic tx_full;
		logic [15:0] rx_word;
		logic rx_full;
		logic pend;
		logic [3:0] cnt;
		logic [15:0] crc;
		logic [15:0] host_crc;
		logic line_d;
	} core_s;

endpackage

// [logic/udma_sync.sv]
// Two-flop synchroniser, one pair per bit
module udma_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	if (WIDTH < 1) begin : g_bad_width
		$error("udma_sync WIDTH must be at least one");
	end

	// Each bit keeps its own flop so no two processes write one variable
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic meta;
		logic flop;
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				meta <= RST_VAL[i];
				flop <= RST_VAL[i];
			end else begin
				meta <= d[i];
				flop <= meta;
			end
		end
		assign q[i] = flop;
	end

endmodule // udma_sync

// [logic/udma_crc.sv]
// One-word step of the burst CRC, bit-serial form unrolled
`include "udma_burst_params.svh"

module udma_crc (
	input wire logic [15:0] crc_in,
	input wire logic [15:0] data,
	output logic [15:0] crc_out
);

	logic [15:0] stage [0:16];

	assign stage[0] = crc_in;

	// Most significant data bit enters first
	for (genvar i = 0; i < 16; i++) begin : g_bit
		logic fb;
		assign fb = stage[i][15] ^ data[15-i];
		assign stage[i+1] = {stage[i][14:0], 1'b0} ^ (fb ? `UDMA_CRC_POLY : 16'h0000);
	end

	assign crc_out = stage[16];

endmodule // udma_crc

// [logic/udma_burst_port.sv]
// Device-side Ultra DMA burst port with register port and pin control
//
// Contract
// - With ultra mode on, DMA reads and writes use bursts; other protocol unchanged.
// - Pins change meaning only with mode, command, request and acknowledge all present.
// - Pins return to normal meanings when the host drops acknowledge.
// - Read burst: host line is ready, device line strobe; write burst reversed.
// - Both strobe edges latch one word each.
// - In IDE mode only the three low address lines are used.
// - Whoever drives data also drives the strobe; device owns it for data-in.
// - Sender places the word first and strobes only after setup time.
// - Any mode up to the fastest supported is accepted.
// - Soft reset keeps the mode unless reverting to defaults is enabled.
// - Power-on or hardware reset clears the ultra mode.
// - Both ends compute a burst CRC; mismatch sets an error flag.
// - Only the first CRC error of a command is reported.
// - On CRC error the device finishes or aborts, reporting the error either way.
// - Every burst transfer is a 16-bit word.
// - Memory-card mode: ready low from command receipt until completion, once.
// - At least one of busy and data-request stays set during a command.
// - Stop ends a burst by host; dropped request ends it by device.
`include "udma_burst_params.svh"

module udma_burst_port #(
	parameter int MAX_MODE = `UDMA_MAX_MODE
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic dmarq,
	input wire logic dmack_n,
	input wire logic stop,
	input wire logic host_line,
	output logic dev_line,
	input wire logic [15:0] data_i,
	output logic [15:0] data_o,
	output logic data_oe,
	input wire logic [10:0] addr_i,
	input wire logic [1:0] ce_n,
	output logic ready,
	output logic [10:0] tf_addr
);

	////////////////////////////////////////////////////////////////////////////////
	// Elaboration checks and constants

	if (MAX_MODE < 0 || MAX_MODE > 6) begin : g_bad_mode
		$error("MAX_MODE must lie in 0 to 6");
	end
	if (`UDMA_DVS_CYC < 1 || `UDMA_DVS_CYC > 15) begin : g_bad_dvs
		$error("Setup count does not fit its counter");
	end

	localparam logic [2:0] MAX_MODE3 = MAX_MODE[2:0];
	localparam logic [3:0] DVS_CYC = 4'(`UDMA_DVS_CYC);
	localparam udma_burst_pkg::link_in_s LINK_IDLE = '{
		addr: 11'h000,
		ce_n: 2'b11,
		dmack_n: 1'b1,
		stop: 1'b0,
		host_line: 1'b1,
		data: 16'h0000
	};

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	udma_burst_pkg::link_in_s link_raw;
	udma_burst_pkg::link_in_s lk;

	assign link_raw.addr = addr_i;
	assign link_raw.ce_n = ce_n;
	assign link_raw.dmack_n = dmack_n;
	assign link_raw.stop = stop;
	assign link_raw.host_line = host_line;
	assign link_raw.data = data_i;

	// Data shares the strobe latency, so it is settled when the edge shows up
	udma_sync #(
		.WIDTH($bits(udma_burst_pkg::link_in_s)),
		.RST_VAL(LINK_IDLE)
	) u_sync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.d(link_raw),
		.q(lk)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Burst CRC

	udma_burst_pkg::core_s c;
	udma_burst_pkg::core_s n;
	logic [15:0] crc_word;
	logic [15:0] crc_next;

	// Sender side hashes the word it drove, recipient side the word it caught
	assign crc_word = c.dir ? c.data_out : lk.data;

	udma_crc u_crc (
		.crc_in(c.crc),
		.data(crc_word),
		.crc_out(crc_next)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Status word

	logic [31:0] status;
	logic drq;

	assign drq = c.cmd_active & (c.count != 16'h0000);

	always_comb begin
		status = 32'h0000_0000;
		status[`UDMA_ST_DRQ] = drq;
		status[`UDMA_ST_BSY] = c.cmd_active & ~drq;
		status[`UDMA_ST_CRCERR] = c.crc_err;
		status[`UDMA_ST_BURST] = (c.st == udma_burst_pkg::ST_BURST);
		status[`UDMA_ST_ACTIVE] = c.cmd_active;
		status[`UDMA_ST_RXFULL] = c.rx_full;
		status[`UDMA_ST_TXEMPTY] = ~c.tx_full;
		status[`UDMA_ST_ABORTED] = c.aborted;
		status[`UDMA_ST_REJECT] = c.reject;
		status[`UDMA_ST_CEVIOL] = c.ceviol;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	logic hack;
	logic hdmardy;
	logic hedge;
	logic step;
	logic data_wr;

	always_comb begin
		n = c;
		hack = ~lk.dmack_n;
		hdmardy = ~lk.host_line;
		hedge = lk.host_line ^ c.line_d;
		step = 1'b0;
		data_wr = reg_wr && (reg_addr == `UDMA_REG_DATA);
		n.line_d = lk.host_line;
		n.rdata = 32'h0000_0000;

		// Register reads answer in the next cycle only
		if (reg_rd) begin
			case (reg_addr)
			`UDMA_REG_CTRL: n.rdata = {30'h0000_0000, c.dir, c.cmd_active};
			`UDMA_REG_MODE: n.rdata = {24'h00_0000, c.abort_en, c.ide, c.memcard,
				c.keep, c.udma_en, c.mode};
			`UDMA_REG_STATUS: n.rdata = status;
			`UDMA_REG_DATA: begin
				n.rdata = {16'h0000, c.rx_word};
				n.rx_full = 1'b0;
			end
			`UDMA_REG_COUNT: n.rdata = {16'h0000, c.count};
			`UDMA_REG_CRC: n.rdata = {c.host_crc, c.crc};
			default: n.rdata = 32'h0000_0000;
			endcase
		end

		if (reg_wr) begin
			case (reg_addr)
			`UDMA_REG_CTRL: begin
				if (reg_wdata[`UDMA_CTRL_SRST]) begin
					n.cmd_active = 1'b0;
					if (!c.keep) begin
						n.udma_en = 1'b0;
						n.mode = `UDMA_MODE_RST;
					end
				end else if (reg_wdata[`UDMA_CTRL_START] && !c.cmd_active) begin
					// Multiword transfers are not served here, so refuse without the mode
					if (c.udma_en && c.count != 16'h0000) begin
						n.cmd_active = 1'b1;
						n.dir = reg_wdata[`UDMA_CTRL_DIR];
						n.crc_err = 1'b0;
						n.aborted = 1'b0;
						n.ceviol = 1'b0;
						n.reject = 1'b0;
					end else begin
						n.reject = 1'b1;
					end
				end
			end
			`UDMA_REG_MODE: begin
				if (!c.cmd_active) begin
					if (reg_wdata[`UDMA_MODE_MSB:`UDMA_MODE_LSB] <= MAX_MODE3) begin
						n.mode = reg_wdata[`UDMA_MODE_MSB:`UDMA_MODE_LSB];
						n.udma_en = reg_wdata[`UDMA_MODE_EN];
					end else begin
						n.reject = 1'b1;
					end
					n.keep = reg_wdata[`UDMA_MODE_KEEP];
					n.memcard = reg_wdata[`UDMA_MODE_MEMCARD];
					n.ide = reg_wdata[`UDMA_MODE_IDE];
					n.abort_en = reg_wdata[`UDMA_MODE_ABORT];
				end
			end
			`UDMA_REG_DATA: begin
				n.tx_word = reg_wdata[15:0];
				n.tx_full = 1'b1;
			end
			`UDMA_REG_COUNT: begin
				if (!c.cmd_active) begin
					n.count = reg_wdata[15:0];
				end
			end
			default: begin
			end
			endcase
		end

		// Burst sequencing
		case (c.st)
		udma_burst_pkg::ST_IDLE: begin
			n.dmarq = 1'b0;
			n.dev_line = 1'b1;
			n.data_oe = 1'b0;
			if (c.cmd_active && c.udma_en && drq && (c.dir ? c.tx_full : !c.rx_full)) begin
				n.dmarq = 1'b1;
				n.st = udma_burst_pkg::ST_REQ;
			end
		end
		udma_burst_pkg::ST_REQ: begin
			if (!c.cmd_active) begin
				n.dmarq = 1'b0;
				n.st = udma_burst_pkg::ST_IDLE;
			end else if (hack) begin
				// Mode, command and request already hold; acknowledge completes the set
				n.st = udma_burst_pkg::ST_BURST;
				n.pend = 1'b0;
				n.dev_line = c.dir ? 1'b1 : c.rx_full;
				if (!c.crc_err) begin
					n.crc = `UDMA_CRC_SEED;
				end
			end
		end
		udma_burst_pkg::ST_BURST: begin
			if (lk.ce_n != 2'b11) begin
				n.ceviol = 1'b1;
			end
			if (!hack || lk.stop || !c.dmarq) begin
				n.dmarq = 1'b0;
				n.st = udma_burst_pkg::ST_TERM;
			end else if (c.dir) begin
				if (!c.pend && c.tx_full && hdmardy && c.count != 16'h0000) begin
					n.data_out = c.tx_word;
					n.data_oe = 1'b1;
					n.tx_full = data_wr;
					n.pend = 1'b1;
					n.cnt = DVS_CYC;
				end else if (c.pend) begin
					if (c.cnt != 4'h0) begin
						n.cnt = c.cnt - 4'h1;
					end else if (hdmardy) begin
						n.dev_line = ~c.dev_line;
						n.pend = 1'b0;
						step = 1'b1;
					end
				end
				if (c.count == 16'h0000 && !c.pend) begin
					n.dmarq = 1'b0;
				end
			end else begin
				// Holding word full pauses the host; an empty count pauses before ending
				n.dev_line = c.rx_full | (c.count == 16'h0000);
				if (hedge) begin
					n.rx_word = lk.data;
					n.rx_full = 1'b1;
					step = 1'b1;
				end
				if (c.count == 16'h0000 && c.dev_line) begin
					n.dmarq = 1'b0;
				end
			end
			if (!c.cmd_active) begin
				n.dmarq = 1'b0;
			end
		end
		udma_burst_pkg::ST_TERM: begin
			n.dmarq = 1'b0;
			n.pend = 1'b0;
			if (!c.dir) begin
				n.dev_line = 1'b1;
			end else if (lk.stop) begin
				// Strobe back to asserted with no data; bus freed for the host CRC
				n.dev_line = 1'b1;
				n.data_oe = 1'b0;
			end
			if (!hack) begin
				n.st = udma_burst_pkg::ST_IDLE;
				n.dev_line = 1'b1;
				n.data_oe = 1'b0;
				if (!c.crc_err) begin
					n.host_crc = lk.data;
					if (lk.data != c.crc) begin
						n.crc_err = 1'b1;
						if (c.abort_en) begin
							n.cmd_active = 1'b0;
							n.aborted = 1'b1;
						end
					end
				end
				if (c.count == 16'h0000) begin
					n.cmd_active = 1'b0;
				end
			end
		end
		default: begin
			n.st = udma_burst_pkg::ST_IDLE;
		end
		endcase

		// Frozen after the first error so the failing pair stays readable
		if (step) begin
			n.count = c.count - 16'h0001;
			if (!c.crc_err) begin
				n.crc = crc_next;
			end
		end

		// In memory-card mode ready falls once at command receipt and rises once at completion
		n.ready = ~(n.memcard & n.cmd_active);
		n.tf_addr = c.ide ? {8'h00, lk.addr[2:0]} : lk.addr;
	end

	////////////////////////////////////////////////////////////////////////////////
	// State registers

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			c <= '0;
			c.st <= udma_burst_pkg::ST_IDLE;
			c.dev_line <= 1'b1;
			c.ready <= 1'b1;
			c.mode <= `UDMA_MODE_RST;
			c.line_d <= 1'b1;
		end else begin
			c <= n;
		end
	end

	assign reg_rdata = c.rdata;
	assign dmarq = c.dmarq;
	assign dev_line = c.dev_line;
	assign data_o = c.data_out;
	assign data_oe = c.data_oe;
	assign ready = c.ready;
	assign tf_addr = c.tf_addr;

endmodule // udma_burst_port

// [bench/udma_burst_port_monitor.sv]
// Pin-level checks on the burst port
module udma_burst_port_monitor (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic reg_wr,
	input wire logic dmarq,
	input wire logic dmack_n,
	input wire logic stop,
	input wire logic dev_line,
	input wire logic [15:0] data_o,
	input wire logic data_oe,
	input wire logic [10:0] addr_i,
	input wire logic ready,
	input wire logic [10:0] tf_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	////////////////////////////////////////////////////////////////
	// Sync latency allowed for: inputs reach the core two edges late
	oe_owner_a: assert property ($rose(data_oe) |-> dmarq && !$past(dmack_n, 3))
		else $error("data driven without acknowledged request");
	line_release_a: assert property ($rose(dmack_n) |-> ##[0:5] (dev_line && !data_oe))
		else $error("pins not returned after acknowledge dropped");
	line_scope_a: assert property ($changed(dev_line) |-> dev_line || !$past(dmack_n, 3))
		else $error("device line driven low outside burst");
	strobe_setup_a: assert property ($changed(dev_line) && data_oe |-> data_o == $past(data_o, 2))
		else $error("word changed too close to strobe edge");
	stop_ack_a: assert property ($rose(stop) |-> ##[0:5] !dmarq)
		else $error("stop not acknowledged");
	ready_fall_a: assert property ($fell(ready) |-> $past(reg_wr))
		else $error("ready fell without a command");
	ready_steady_a: assert property ($fell(dmarq) && !ready |=> !ready)
		else $error("ready toggled within a command");
	addr_low_a: assert property ($stable(addr_i) [*5] |-> tf_addr[2:0] == addr_i[2:0])
		else $error("low address lines not passed on");

	cover property ($rose(data_oe));
	cover property ($fell(ready));
	cover property ($rose(stop) && dmarq);
endmodule // udma_burst_port_monitor

bind udma_burst_port udma_burst_port_monitor mon (.clk_sys, .rstn, .reg_wr, .dmarq, .dmack_n,
	.stop, .dev_line, .data_o, .data_oe, .addr_i, .ready, .tf_addr);

// [bench/udma_host_model.sv]
// Host end of the burst link, timed in its own phase
module udma_host_model (
	input wire logic dmarq,
	input wire logic dev_line,
	input wire logic [15:0] data_o,
	output logic dmack_n,
	output logic stop,
	output logic host_line,
	output logic [15:0] data_i
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 160;
	// Skew keeps pin changes clear of the sampling edge
	localparam int SKEW = 13;
	logic [15:0] crc;

	initial begin
		dmack_n = 1'b1;
		stop = 1'b0;
		host_line = 1'b1;
		data_i = 16'h0000;
	end

	////////////////////////////////////////////////////////////////
	function automatic logic [15:0] crc16(input logic [15:0] c, input logic [15:0] d);
		for (int i = 15; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
		return c;
	endfunction

	task automatic open_burst(input logic in_dir);
		wait (dmarq === 1'b1);
		#(HALF + SKEW);
		crc = 16'hffff;
		host_line = !in_dir;
		dmack_n = 1'b0;
	endtask

	task automatic send_word(input logic [15:0] w);
		wait (dev_line === 1'b0);
		#SKEW;
		data_i = w;
		#(HALF / 2);
		host_line = !host_line;
		crc = crc16(crc, w);
		#(HALF / 2);
	endtask

	task automatic take_word(output logic [15:0] w);
		@(dev_line);
		w = data_o;
		crc = crc16(crc, w);
	endtask

	task automatic close_burst(input logic bad);
		#SKEW;
		stop = 1'b1;
		wait (dmarq === 1'b0);
		#(HALF + SKEW);
		data_i = crc ^ {15'h0000, bad};
		#HALF;
		dmack_n = 1'b1;
		#HALF;
		data_i = ~data_i;
		stop = 1'b0;
		host_line = 1'b1;
	endtask
endmodule // udma_host_model

// [bench/udma_burst_port_test.sv]
// Self-checking bench for the burst port
`include "udma_burst_params.svh"

module udma_burst_port_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int MAXM = 4;
	logic clk_sys, rstn, reg_wr, reg_rd, dmarq, dmack_n, stop, host_line, dev_line;
	logic data_oe, ready;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [15:0] data_i, data_o, w, e1;
	logic [10:0] addr_i, tf_addr;
	logic [1:0] ce_n;
	int n_mismatch, total_checks, cycles;

	udma_burst_port #(.MAX_MODE(MAXM)) dut (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .dmarq, .dmack_n, .stop, .host_line, .dev_line, .data_i,
		.data_o, .data_oe, .addr_i, .ce_n, .ready, .tf_addr);
	udma_host_model host (.dmarq, .dev_line, .data_o, .dmack_n, .stop, .host_line, .data_i);

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask

	// Data stand one cycle only, so taken at the edge that closes that cycle
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		check($sformatf("reg %h", a), e, reg_rdata & m);
	endtask

	task automatic xfer_out(input logic [15:0] d);
		host.open_burst(1'b0);
		host.send_word(d);
		host.close_burst(1'b1);
		repeat (8) @(posedge clk_sys);
		rd(`UDMA_REG_DATA, 32'hffff, {16'h0000, d});
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		rstn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		addr_i = 11'h000;
		ce_n = 2'h3;
		repeat (16) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		check("idle pins", 32'h3, {30'h0, ready, dev_line});
		rd(`UDMA_REG_MODE, 32'hff, 32'h0);
		for (int m = 0; m <= MAXM; m++) begin
			wr(`UDMA_REG_MODE, 32'h8 | m);
			rd(`UDMA_REG_MODE, 32'hf, 32'h8 | m);
		end
		wr(`UDMA_REG_MODE, 32'h8 | (MAXM + 1));
		rd(`UDMA_REG_STATUS, 32'h100, 32'h100);
		rd(`UDMA_REG_MODE, 32'hf, 32'h8 | MAXM);
		rd(8'hfc, 32'hffffffff, 32'h0);
		wr(`UDMA_REG_MODE, 32'h0);
		wr(`UDMA_REG_COUNT, 32'h1);
		wr(`UDMA_REG_CTRL, 32'h1);
		rd(`UDMA_REG_STATUS, 32'h110, 32'h100);
		$display("test modes done");
		wr(`UDMA_REG_MODE, 32'h1b);
		wr(`UDMA_REG_CTRL, 32'h4);
		rd(`UDMA_REG_MODE, 32'h1f, 32'h1b);
		wr(`UDMA_REG_MODE, 32'hb);
		wr(`UDMA_REG_CTRL, 32'h4);
		rd(`UDMA_REG_MODE, 32'h1f, 32'h0);
		$display("test soft reset done");
		wr(`UDMA_REG_MODE, 32'h6a);
		addr_i <= 11'h7f8;
		wr(`UDMA_REG_DATA, 32'ha5c3);
		wr(`UDMA_REG_COUNT, 32'h1);
		wr(`UDMA_REG_CTRL, 32'h3);
		repeat (3) @(posedge clk_sys);
		check("ready", 32'h0, 32'(ready));
		check("tf_addr", 32'h0, 32'(tf_addr));
		rd(`UDMA_REG_STATUS, 32'h13, 32'h12);
		host.open_burst(1'b1);
		host.take_word(w);
		check("word in", 32'ha5c3, 32'(w));
		check("data_oe", 32'h1, 32'(data_oe));
		host.close_burst(1'b0);
		repeat (8) @(posedge clk_sys);
		check("ready", 32'h1, 32'(ready));
		check("data_oe", 32'h0, 32'(data_oe));
		rd(`UDMA_REG_STATUS, 32'h57, 32'h40);
		$display("test data in done");
		wr(`UDMA_REG_MODE, 32'h9);
		wr(`UDMA_REG_COUNT, 32'h2);
		wr(`UDMA_REG_CTRL, 32'h1);
		xfer_out(16'h1234);
		e1 = host.crc;
		xfer_out(16'hbeef);
		rd(`UDMA_REG_STATUS, 32'h294, 32'h4);
		rd(`UDMA_REG_CRC, 32'hffffffff, {e1 ^ 16'h0001, e1});
		$display("test data out done");
		wr(`UDMA_REG_MODE, 32'h89);
		wr(`UDMA_REG_COUNT, 32'h2);
		wr(`UDMA_REG_CTRL, 32'h1);
		xfer_out(16'h0ff0);
		rd(`UDMA_REG_STATUS, 32'h94, 32'h84);
		$display("test abort done");
		rstn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		rd(`UDMA_REG_MODE, 32'hff, 32'h0);
		$display("test hard reset done");
		finish_test();
	end
endmodule // udma_burst_port_test
